/* verilog/interrupt_priority_edge_control.sv */
// Interrupt priority flags, edge selection, pin zero noise filter, PSW.
// Assumes CPU strobes are one-cycle pulses synchronous to clk.
// Functional notes
// - Reset sets all three priority flag registers to ff.
// - Low edge register selects edges for pins zero..two and captures.
// - High edge register selects edges for pins three..five, two bits each.
// - Reset clears both edge registers, so inputs start falling-active.
// - Edge field: 00 fall, 01 rise, 11 both; 10 is forbidden.
// - Capture A edges come from low edge register bits 2 and 3, capture B from bits 4 and 5.
// - Pin zero and one edges may change while the timer runs.
// - Sample select register picks the pin zero sampling clock.
// - Reset clears the sample select register.
// - Pin zero request only after two consecutive active samples.
// - Pulse shorter than a sample period, unseen, sets no request.
// - CPU-derived sample clock stops in HALT; peripheral ones run.
// - PSW holds enable and in-service flag; byte, bit, EI, DI writes.
// - Vectored ack or break saves PSW and clears global enable.
// - Maskable ack copies source priority flag into in-service flag.
// - PSW restored on returns and pop, pushed on push-status.
// - Reset loads PSW with 02.
// - Priority registers take bit, byte and paired 16-bit writes.
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_edge_control
  import irq_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_bit_mask,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr16,
  input wire logic [15:0] reg_wdata16,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic enable_instr,
  input wire logic disable_instr,
  input wire logic ack_vectored,
  input wire logic ack_maskable,
  input wire logic [4:0] ack_source,
  input wire logic software_break_instr,
  input wire logic push_status_instr,
  input wire logic psw_restore,
  input wire logic [7:0] psw_restore_data,
  output logic [7:0] psw_save_data,
  output logic psw_save_strobe,
  input wire logic halt_mode,
  input wire logic cpu_sample_tick,
  input wire logic [5:0] ext_irq_pins,
  input wire logic timer_capture_in_a,
  input wire logic timer_capture_in_b,
  output logic [5:0] pin_request_pulse,
  output logic [1:0] capture_edge_pulse,
  output logic [7:0] priority_flags_low,
  output logic [7:0] priority_flags_high,
  output logic [7:0] priority_flags_third,
  output logic [7:0] program_status_word
);

  function automatic logic edge_hit(input logic [1:0] mode,
                                    input logic prev, input logic cur);
    case (mode)
      EDGE_FALL: edge_hit = prev & ~cur;
      EDGE_RISE: edge_hit = ~prev & cur;
      EDGE_BOTH: edge_hit = prev ^ cur;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  function automatic logic wsel(input logic [15:0] a,
                                input logic [15:0] target);
    wsel = reg_wr && (a == target);
  endfunction : wsel

  logic [7:0] edge_select_low_pins_r;
  logic [7:0] edge_select_high_pins_r;
  logic [7:0] noise_sample_clock_select_r;
  logic [DIV_W-1:0] div_cnt_r;
  logic sample_tick;
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] prev_r;
  logic samp_r;
  logic filt_r;
  logic filt_prev_r;
  logic [7:0] raw_in;
  logic [NUM_SRC-1:0] prio_all;
  logic [7:0] psw_nxt;

  assign raw_in = {timer_capture_in_b, timer_capture_in_a, ext_irq_pins};
  assign prio_all = {priority_flags_third, priority_flags_high,
                     priority_flags_low};

  // Priority flags: bitwise masked writes, or a word write to the pair
  always_ff @(posedge clk) begin
    if (!rstn) begin
      priority_flags_low <= PRIO_RESET;
      priority_flags_high <= PRIO_RESET;
      priority_flags_third <= PRIO_RESET;
    end else if (reg_wr16 && reg_addr == ADDR_PRIO_LOW) begin
      priority_flags_low <= reg_wdata16[7:0];
      priority_flags_high <= reg_wdata16[15:8];
    end else begin
      if (wsel(reg_addr, ADDR_PRIO_LOW))
        priority_flags_low <= (priority_flags_low & ~reg_bit_mask) |
                              (reg_wdata & reg_bit_mask);
      if (wsel(reg_addr, ADDR_PRIO_HIGH))
        priority_flags_high <= (priority_flags_high & ~reg_bit_mask) |
                               (reg_wdata & reg_bit_mask);
      if (wsel(reg_addr, ADDR_PRIO_THIRD))
        priority_flags_third <= (priority_flags_third & ~reg_bit_mask) |
                                (reg_wdata & reg_bit_mask);
    end
  end

  // Edge and sample registers are whole-byte; the bit mask is ignored
  always_ff @(posedge clk) begin
    if (!rstn) begin
      edge_select_low_pins_r <= EDGE_RESET;
      edge_select_high_pins_r <= EDGE_RESET;
    end else begin
      // No timer interlock: pin edges may change at any time
      if (wsel(reg_addr, ADDR_EDGE_LOW))
        edge_select_low_pins_r <= reg_wdata & EDGE_LOW_MASK;
      if (wsel(reg_addr, ADDR_EDGE_HIGH))
        edge_select_high_pins_r <= reg_wdata & EDGE_HIGH_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn)
      noise_sample_clock_select_r <= SAMPLE_SEL_RESET;
    else if (wsel(reg_addr, ADDR_SAMPLE_SEL))
      noise_sample_clock_select_r <= reg_wdata & SAMPLE_SEL_MASK;
  end

  always_ff @(posedge clk) begin
    if (!rstn)
      div_cnt_r <= '0;
    else
      div_cnt_r <= div_cnt_r + 1'b1;
  end

  // CPU tick gated by HALT; prescaled ticks keep running
  always_comb begin
    case (noise_sample_clock_select_r[1:0])
      SCS_CPU: sample_tick = cpu_sample_tick & ~halt_mode;
      SCS_DIV32: sample_tick = &div_cnt_r[4:0];
      SCS_DIV64: sample_tick = &div_cnt_r[5:0];
      SCS_DIV128: sample_tick = &div_cnt_r;
      default: sample_tick = 1'b0;
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (!rstn) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          prev_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= raw_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          prev_r[gi] <= sync2_r[gi];
        end
      end
    end
  endgenerate

  // Filtered level moves only when two samples in a row agree
  always_ff @(posedge clk) begin
    if (!rstn) begin
      samp_r <= 1'b0;
      filt_r <= 1'b0;
      filt_prev_r <= 1'b0;
    end else begin
      filt_prev_r <= filt_r;
      if (sample_tick) begin
        samp_r <= sync2_r[0];
        if (sync2_r[0] == samp_r)
          filt_r <= samp_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_request_pulse <= '0;
      capture_edge_pulse <= '0;
    end else begin
      pin_request_pulse[0] <= edge_hit(
        edge_select_low_pins_r[CAP_A_LO +: 2], filt_prev_r, filt_r);
      pin_request_pulse[1] <= edge_hit(
        edge_select_low_pins_r[CAP_B_LO +: 2], prev_r[1], sync2_r[1]);
      pin_request_pulse[2] <= edge_hit(
        edge_select_low_pins_r[PIN_TWO_LO +: 2], prev_r[2], sync2_r[2]);
      for (int i = 0; i < 3; i++)
        pin_request_pulse[3+i] <= edge_hit(
          edge_select_high_pins_r[2*i +: 2],
          prev_r[3+i], sync2_r[3+i]);
      capture_edge_pulse[0] <= edge_hit(
        edge_select_low_pins_r[CAP_A_LO +: 2], prev_r[6], sync2_r[6]);
      capture_edge_pulse[1] <= edge_hit(
        edge_select_low_pins_r[CAP_B_LO +: 2], prev_r[7], sync2_r[7]);
    end
  end

  // PSW: acknowledge beats restore beats byte write beats EI and DI
  always_comb begin
    psw_nxt = program_status_word;
    if (ack_vectored || software_break_instr) begin
      psw_nxt[PSW_IE_BIT] = 1'b0;
      if (ack_vectored && ack_maskable)
        psw_nxt[PSW_ISP_BIT] = prio_all[ack_source];
    end else if (psw_restore) begin
      psw_nxt = psw_restore_data;
    end else if (wsel(reg_addr, ADDR_PSW)) begin
      psw_nxt = (program_status_word & ~reg_bit_mask) |
                (reg_wdata & reg_bit_mask);
    end else if (enable_instr) begin
      psw_nxt[PSW_IE_BIT] = 1'b1;
    end else if (disable_instr) begin
      psw_nxt[PSW_IE_BIT] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn)
      program_status_word <= PSW_RESET;
    else
      program_status_word <= psw_nxt;
  end

  // Saved image is the PSW before the acknowledge changes it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      psw_save_data <= '0;
      psw_save_strobe <= 1'b0;
    end else begin
      psw_save_strobe <= ack_vectored | software_break_instr |
                         push_status_instr;
      if (ack_vectored || software_break_instr || push_status_instr)
        psw_save_data <= program_status_word;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_PRIO_LOW: reg_rdata <= priority_flags_low;
        ADDR_PRIO_HIGH: reg_rdata <= priority_flags_high;
        ADDR_PRIO_THIRD: reg_rdata <= priority_flags_third;
        ADDR_EDGE_LOW: reg_rdata <= edge_select_low_pins_r;
        ADDR_EDGE_HIGH: reg_rdata <= edge_select_high_pins_r;
        ADDR_SAMPLE_SEL: reg_rdata <= noise_sample_clock_select_r;
        ADDR_PSW: reg_rdata <= program_status_word;
        default: reg_rdata <= '0;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_pin_stable_high;
    sync2_r[0] [*2];
  endsequence

  AST_PRIO_RESET: assert property (
    $rose(rstn) |-> priority_flags_low == PRIO_RESET &&
    priority_flags_high == PRIO_RESET &&
    priority_flags_third == PRIO_RESET)
    else $error("priority flags not ff after reset");
  AST_EDGE_RESET: assert property (
    $rose(rstn) |-> edge_select_high_pins_r == EDGE_RESET &&
    edge_select_low_pins_r == EDGE_RESET)
    else $error("edge registers not cleared");
  AST_PSW_RESET: assert property (
    $rose(rstn) |-> program_status_word == PSW_RESET)
    else $error("psw reset value wrong");
  AST_SCS_RESET: assert property (
    $rose(rstn) |-> noise_sample_clock_select_r == SAMPLE_SEL_RESET)
    else $error("sample select not cleared");
  AST_ACK_CLEARS_IE: assert property (
    (ack_vectored || software_break_instr) |=>
    !program_status_word[PSW_IE_BIT] && psw_save_strobe &&
    psw_save_data == $past(program_status_word))
    else $error("ack did not save psw and clear enable");
  AST_ISP_COPY: assert property (
    (ack_vectored && ack_maskable) |=>
    program_status_word[PSW_ISP_BIT] == $past(prio_all[ack_source]))
    else $error("in-service flag not copied");
  AST_RESTORE: assert property (
    (psw_restore && !ack_vectored && !software_break_instr) |=>
    program_status_word == $past(psw_restore_data))
    else $error("psw not restored");
  AST_FORBIDDEN_CODE: assert property (
    edge_select_high_pins_r[1:0] == 2'h2 |=> !pin_request_pulse[3])
    else $error("forbidden edge code fired");
  // Watch the sample itself, so a broken tick gate is caught
  AST_HALT_NO_SAMPLE: assert property (
    (halt_mode && noise_sample_clock_select_r[1:0] == SCS_CPU)
    |=> $stable(samp_r))
    else $error("cpu sample clock ran in halt");
  AST_ONE_PULSE: assert property (
    pin_request_pulse[4] |=> !pin_request_pulse[4])
    else $error("two pulses for one edge");
  AST_FILTER_NEEDS_TWO: assert property (
    $rose(filt_r) |-> $past(samp_r) && $past(sync2_r[0]))
    else $error("filter moved on one sample");
  AST_RISE_PIN_TWO: assert property (
    (edge_select_low_pins_r[7:6] == EDGE_RISE && !prev_r[2] && sync2_r[2]
    && $stable(edge_select_low_pins_r)) |=> pin_request_pulse[2])
    else $error("pin two rising edge missed");

endmodule : interrupt_priority_edge_control
`default_nettype wire

/* include/irq_ctrl_pkg.sv */
// Constants for the interrupt priority and edge control block.
// Assumes byte-wide CPU register access at 16-bit data addresses.
package irq_ctrl_pkg;
  localparam logic [15:0] ADDR_PRIO_LOW = 16'hffe8;
  localparam logic [15:0] ADDR_PRIO_HIGH = 16'hffe9;
  localparam logic [15:0] ADDR_PRIO_THIRD = 16'hffea;
  localparam logic [15:0] ADDR_EDGE_LOW = 16'hffec;
  localparam logic [15:0] ADDR_EDGE_HIGH = 16'hffed;
  localparam logic [15:0] ADDR_SAMPLE_SEL = 16'hffe7;
  localparam logic [15:0] ADDR_PSW = 16'hff1e;
  localparam logic [7:0] PRIO_RESET = 8'hff;
  localparam logic [7:0] EDGE_RESET = 8'h00;
  localparam logic [7:0] SAMPLE_SEL_RESET = 8'h00;
  localparam logic [7:0] PSW_RESET = 8'h02;
  localparam logic [7:0] EDGE_HIGH_MASK = 8'h3f;
  localparam logic [7:0] EDGE_LOW_MASK = 8'hfc;
  localparam logic [7:0] SAMPLE_SEL_MASK = 8'h03;
  localparam int PSW_IE_BIT = 7;
  localparam int PSW_ISP_BIT = 1;
  localparam int CAP_A_LO = 2;
  localparam int CAP_B_LO = 4;
  localparam int PIN_TWO_LO = 6;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] SCS_CPU = 2'h0;
  localparam logic [1:0] SCS_DIV32 = 2'h1;
  localparam logic [1:0] SCS_DIV64 = 2'h2;
  localparam logic [1:0] SCS_DIV128 = 2'h3;
  localparam int DIV_W = 7;
  localparam int NUM_SRC = 24;
endpackage : irq_ctrl_pkg

/* testbench/psw_stack_model.sv */
// CPU stack model: keeps saved status words, hands them back on pop.
// Assumes pops only follow pushes; idle restore data wanders.
`timescale 1ns/1ps
`default_nettype none
module psw_stack_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psw_save_strobe,
  input wire logic [7:0] psw_save_data,
  input wire logic pop_req,
  output logic psw_restore,
  output logic [7:0] psw_restore_data
);
  logic [7:0] stack_r[$];
  always @(posedge clk) begin
    psw_restore <= 1'b0;
    // Stale data must not look valid
    psw_restore_data <= ~psw_restore_data;
    if (!rstn) begin
      psw_restore_data <= 8'h5a;
      stack_r.delete();
    end else begin
      if (psw_save_strobe) begin
        stack_r.push_back(psw_save_data);
      end
      if (pop_req && stack_r.size() > 0) begin
        psw_restore <= 1'b1;
        psw_restore_data <= stack_r.pop_back();
      end
    end
  end
endmodule : psw_stack_model
`default_nettype wire

/* testbench/interrupt_priority_edge_control_test.sv */
// Self-checking bench for the interrupt priority and edge control block.
// Assumes a 50 MHz clock and the stack model on the status word port.
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_edge_control_test;
  import irq_ctrl_pkg::*;
  logic clk = 1'b0, rstn = 1'b0;
  logic [15:0] reg_addr = 16'h0000, reg_wdata16 = 16'h0000, w;
  logic [7:0] reg_bit_mask = 8'hff, reg_wdata = 8'h00, v;
  logic reg_wr = 1'b0, reg_wr16 = 1'b0, reg_rd = 1'b0, pop_req = 1'b0;
  logic enable_instr = 1'b0, disable_instr = 1'b0, ack_vectored = 1'b0;
  logic ack_maskable = 1'b0, software_break_instr = 1'b0, rd_d = 1'b0;
  logic push_status_instr = 1'b0, halt_mode = 1'b0, cpu_sample_tick = 1'b0;
  logic timer_capture_in_a = 1'b0, timer_capture_in_b = 1'b0;
  logic [4:0] ack_source = 5'h00, s5;
  logic [5:0] ext_irq_pins = 6'h00, pin_request_pulse;
  logic [7:0] reg_rdata, psw_save_data, psw_restore_data, program_status_word;
  logic [7:0] priority_flags_low, priority_flags_high, priority_flags_third;
  logic [7:0] exp_rd[$], exp_pl[$], exp_sv[$];
  logic [1:0] capture_edge_pulse, m;
  logic psw_save_strobe, psw_restore;
  logic [31:0] rng = 32'd12464;
  logic [23:0] prio;
  int mismatches = 0, checks = 0;

  interrupt_priority_edge_control dut (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_bit_mask(reg_bit_mask),
    .reg_wdata(reg_wdata), .reg_wr16(reg_wr16), .reg_wdata16(reg_wdata16),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enable_instr(enable_instr),
    .disable_instr(disable_instr), .ack_vectored(ack_vectored),
    .ack_maskable(ack_maskable), .ack_source(ack_source),
    .software_break_instr(software_break_instr),
    .push_status_instr(push_status_instr), .psw_restore(psw_restore),
    .psw_restore_data(psw_restore_data), .psw_save_data(psw_save_data),
    .psw_save_strobe(psw_save_strobe), .halt_mode(halt_mode),
    .cpu_sample_tick(cpu_sample_tick), .ext_irq_pins(ext_irq_pins),
    .timer_capture_in_a(timer_capture_in_a),
    .timer_capture_in_b(timer_capture_in_b),
    .pin_request_pulse(pin_request_pulse),
    .capture_edge_pulse(capture_edge_pulse),
    .priority_flags_low(priority_flags_low),
    .priority_flags_high(priority_flags_high),
    .priority_flags_third(priority_flags_third),
    .program_status_word(program_status_word));

  psw_stack_model stack (.clk(clk), .rstn(rstn),
    .psw_save_strobe(psw_save_strobe), .psw_save_data(psw_save_data),
    .pop_req(pop_req), .psw_restore(psw_restore),
    .psw_restore_data(psw_restore_data));

  always #10 clk = ~clk;

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  task automatic cmp(input string what, input logic [7:0] e,
                     input logic [7:0] g, input bit have);
    checks++;
    if (!have || g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : cmp

  // No note left means the result was never asked for
  task automatic cmp_rd(input logic [7:0] g);
    cmp("read data", (exp_rd.size() > 0) ? exp_rd[0] : 8'h00, g,
        exp_rd.size() > 0);
    if (exp_rd.size() > 0) exp_rd.delete(0);
  endtask : cmp_rd

  task automatic cmp_pl(input logic [7:0] g);
    cmp("edge pulses", (exp_pl.size() > 0) ? exp_pl[0] : 8'h00, g,
        exp_pl.size() > 0);
    if (exp_pl.size() > 0) exp_pl.delete(0);
  endtask : cmp_pl

  task automatic cmp_sv(input logic [7:0] g);
    cmp("saved psw", (exp_sv.size() > 0) ? exp_sv[0] : 8'h00, g,
        exp_sv.size() > 0);
    if (exp_sv.size() > 0) exp_sv.delete(0);
  endtask : cmp_sv

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  task automatic wr(input logic [15:0] a, input logic [7:0] d,
                    input logic [7:0] msk = 8'hff);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_bit_mask <= msk;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_rd.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic op(input int k);
    @(posedge clk);
    case (k)
      0: enable_instr <= 1'b1;
      1: disable_instr <= 1'b1;
      2: software_break_instr <= 1'b1;
      3: push_status_instr <= 1'b1;
      4: pop_req <= 1'b1;
      default: begin
        ack_vectored <= 1'b1;
        ack_maskable <= (k == 5);
        ack_source <= s5;
      end
    endcase
    @(posedge clk);
    {enable_instr, disable_instr, software_break_instr} <= 3'b000;
    {push_status_instr, pop_req, ack_vectored, ack_maskable} <= 4'h0;
  endtask : op

  task automatic hold(input logic [7:0] lv, input int n);
    @(posedge clk);
    timer_capture_in_b <= lv[7];
    timer_capture_in_a <= lv[6];
    ext_irq_pins <= lv[5:0];
    repeat (n) @(posedge clk);
  endtask : hold

  // Results are matched oldest first against the notes
  always @(posedge clk) begin
    cpu_sample_tick <= ~cpu_sample_tick;
    rd_d <= reg_rd;
    if (rd_d) cmp_rd(reg_rdata);
    // Outputs are unknown before the first reset edge
    if (rstn && {capture_edge_pulse, pin_request_pulse} !== 8'h00)
      cmp_pl({capture_edge_pulse, pin_request_pulse});
    if (psw_save_strobe) cmp_sv(psw_save_data);
  end

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(ADDR_PRIO_LOW, PRIO_RESET);
    rd(ADDR_PRIO_HIGH, PRIO_RESET);
    rd(ADDR_PRIO_THIRD, PRIO_RESET);
    rd(ADDR_EDGE_LOW, 8'h00);
    rd(ADDR_EDGE_HIGH, 8'h00);
    rd(ADDR_SAMPLE_SEL, 8'h00);
    rd(ADDR_PSW, 8'h02);
    rd(16'hffee, 8'h00);
    $display("test reset values done");
    wr(ADDR_EDGE_HIGH, 8'hff);
    rd(ADDR_EDGE_HIGH, 8'h3f);
    wr(ADDR_EDGE_LOW, 8'hff);
    rd(ADDR_EDGE_LOW, 8'hfc);
    wr(ADDR_SAMPLE_SEL, 8'hff);
    rd(ADDR_SAMPLE_SEL, 8'h03);
    wr(ADDR_PRIO_LOW, 8'h00, 8'h02); // bit clear
    rd(ADDR_PRIO_LOW, 8'hfd);
    for (int i = 0; i < 3; i++) begin
      rng = xorshift(rng);
      w = rng[15:0] | 16'h0081;
      prio = {rng[23:16] | 8'hf8, w};
      @(posedge clk);
      reg_addr <= ADDR_PRIO_LOW;
      reg_wdata16 <= w;
      reg_wr16 <= 1'b1;
      @(posedge clk);
      reg_wr16 <= 1'b0;
      wr(ADDR_PRIO_THIRD, prio[23:16]);
      rd(ADDR_PRIO_LOW, w[7:0]);
      rd(ADDR_PRIO_HIGH, w[15:8]);
      rd(ADDR_PRIO_THIRD, prio[23:16]);
    end
    $display("test register access done");
    // Timer assumed stopped, so capture edges may change
    for (int i = 0; i < 4; i++) begin
      m = 2'(i);
      wr(ADDR_EDGE_LOW, {m, m, m, 2'b00});
      wr(ADDR_EDGE_HIGH, {2'b00, m, m, m});
      rng = xorshift(rng);
      v = (rng[7:0] & 8'hfe) | 8'h02;
      if (m[0]) exp_pl.push_back(v);
      hold(v, 8);
      if (m[1] == m[0]) exp_pl.push_back(v);
      hold(8'h00, 8);
    end
    $display("test edge selection done");
    wr(ADDR_EDGE_LOW, 8'h0c);
    @(posedge clk);
    halt_mode <= 1'b1;
    for (int s = 1; s < 4; s++) begin
      wr(ADDR_SAMPLE_SEL, 8'(s));
      hold(8'h01, 20);
      hold(8'h00, 3 * (16 << s));
      exp_pl.push_back(8'h01);
      hold(8'h01, 3 * (16 << s) + 8);
      exp_pl.push_back(8'h01);
      hold(8'h00, 3 * (16 << s) + 8);
    end
    wr(ADDR_SAMPLE_SEL, 8'h00);
    hold(8'h01, 40);
    halt_mode <= 1'b0;
    exp_pl.push_back(8'h01);
    hold(8'h01, 20);
    exp_pl.push_back(8'h01);
    hold(8'h00, 20);
    $display("test noise filter done");
    op(0);
    rd(ADDR_PSW, 8'h82);
    op(1);
    rd(ADDR_PSW, 8'h02);
    wr(ADDR_PSW, 8'hff, 8'h80);
    rd(ADDR_PSW, 8'h82);
    for (int i = 0; i < 4; i++) begin
      rng = xorshift(rng);
      s5 = 5'(rng[4:0] % 5'd24);
      // Odd rounds are non-maskable: in-service flag must stay set
      v = (i % 2) ? 8'h82 : 8'h80;
      wr(ADDR_PSW, v);
      exp_sv.push_back(v);
      op(5 + i % 2);
      rd(ADDR_PSW, (i % 2) ? 8'h02 : {6'h00, prio[s5], 1'b0});
    end
    wr(ADDR_PSW, 8'h82);
    exp_sv.push_back(8'h82);
    op(2);
    rd(ADDR_PSW, 8'h02);
    wr(ADDR_PSW, 8'h81);
    exp_sv.push_back(8'h81);
    op(3);
    wr(ADDR_PSW, 8'h00);
    op(4);
    rd(ADDR_PSW, 8'h81);
    $display("test status word done");
    for (int t = 0; t < 50; t++) begin
      if (exp_rd.size() + exp_pl.size() + exp_sv.size() > 0) @(posedge clk);
    end
    if (exp_rd.size() + exp_pl.size() + exp_sv.size() > 0) begin
      mismatches++;
      $display("MISMATCH pending results expected 0 seen %0d",
               exp_rd.size() + exp_pl.size() + exp_sv.size());
    end
    test_done();
  end
endmodule : interrupt_priority_edge_control_test
`default_nettype wire
